/* pld_pkg.sv */
// Shared sizes, register map, field positions and codes of the logic block.
// Assumes a 32-bit, word-addressed Avalon-MM register bus.
package pld_pkg;
   // Block geometry
   localparam int N_IN = 26;
   localparam int N_MC = 16;
   localparam int N_LOGIC = 64;
   localparam int N_ALL = 70;
   localparam int CL_SZ = 4;
   localparam int MAX_PT = 12;
   localparam int N_CLK = 4;
   localparam int BANK = 8;
   localparam int CFG_W = 8;
   // Special-purpose term indices
   localparam int T_OE = 64;
   localparam int T_AR = 68;
   localparam int T_AP = 69;
   // Register word offsets
   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_STATUS = 8'h01;
   localparam logic [7:0] OFS_STEER = 8'h02;
   localparam logic [7:0] OFS_MC = 8'h10;
   localparam logic [7:0] OFS_TERM = 8'h40;
   // Field positions
   localparam int CTRL_RUN = 0;
   localparam int MC_REG = 0;
   localparam int MC_INV = 1;
   localparam int MC_TT = 2;
   localparam int MC_CK = 3;
   localparam int MC_OE = 5;
   localparam int MC_OES = 7;
   // Driver modes
   localparam logic [1:0] OE_OFF = 2'h0;
   localparam logic [1:0] OE_ON = 2'h1;
   localparam logic [1:0] OE_PT = 2'h2;
   // Cluster steering codes
   localparam logic [1:0] ST_NONE = 2'h0;
   localparam logic [1:0] ST_DOWN = 2'h1;
   localparam logic [1:0] ST_OWN = 2'h2;
   localparam logic [1:0] ST_UP = 2'h3;
   // Values after reset
   localparam logic RST_RUN = 1'b0;
   localparam logic [CFG_W-1:0] RST_CFG = 8'h00;
   localparam logic [31:0] RST_STEER = 32'h0000_0000;
endpackage

/* pld_macrocell.sv */
// One macrocell: D or T flip-flop, registered or combinational, polarity.
// Assumes clock pins arrive as edge flags already timed to the core clock.
`timescale 1ns/1ps
module pld_macrocell
   import pld_pkg::*;
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic rst_b_i,
   // Configuration
   input wire logic run_i,
   input wire logic [CFG_W-1:0] cfg_i,
   // Logic inputs
   input wire logic sum_i,
   input wire logic [N_CLK-1:0] clk_edge_i,
   input wire logic ar_i,
   input wire logic ap_i,
   // Result, also the internal feedback
   output logic out_o
);
   logic q; // Flip-flop state
   logic next_q;
   logic next_out;
   logic [1:0] ck; // Selected global clock

   assign ck = cfg_i[MC_CK +: 2];

   // Next state; reset term beats preset term when both are true
   always_comb begin
      next_q = q;
      if (!run_i) begin
         next_q = 1'b0;
      end else if (ar_i) begin
         next_q = 1'b0;
      end else if (ap_i) begin
         next_q = 1'b1;
      end else if (clk_edge_i[ck]) begin
         // Toggle on a true sum, else hold; D loads the sum
         next_q = cfg_i[MC_TT] ? (q ^ sum_i) : sum_i;
      end
      // Same value goes to pin and back to the matrix
      next_out = 1'b0;
      if (run_i) begin
         next_out = (cfg_i[MC_REG] ? next_q : sum_i) ^ cfg_i[MC_INV];
      end
   end

   // Register state and output
   always_ff @(posedge clk_i) begin
      if (!rst_b_i) begin
         q <= 1'b0;
         out_o <= 1'b0;
      end else begin
         q <= next_q;
         out_o <= next_out;
      end
   end

   default clocking @(posedge clk_i); endclocking
   default disable iff (!rst_b_i);

   toggle_flip_a: assert property (run_i && !ar_i && !ap_i && cfg_i[MC_TT] &&
      clk_edge_i[ck] && sum_i |=> q != $past(q)) else $error("T cell did not toggle");
   edge_only_a: assert property (run_i && !ar_i && !ap_i && !clk_edge_i[ck]
      |=> $stable(q)) else $error("State moved without clock edge");
   async_reset_a: assert property (run_i && ar_i |=> !q)
      else $error("Reset term did not clear state");
   async_preset_a: assert property (run_i && !ar_i && ap_i |=> q)
      else $error("Preset term did not set state");
   comb_path_a: assert property (run_i && !cfg_i[MC_REG]
      |=> out_o == ($past(sum_i) ^ $past(cfg_i[MC_INV]))) else $error("Bad comb output");
   toggle_c: cover property (run_i && cfg_i[MC_TT] && clk_edge_i[ck] && sum_i);
endmodule

/* pld_block.sv */
// Programmable sum-of-products logic block with Avalon-MM configuration.
// Assumes matrix inputs, clock pins and pin levels are synchronous to CLOCK_I.
//
// The Avalon-MM register port and the register offsets were decided locally.
`timescale 1ns/1ps
module pld_block
   import pld_pkg::*;
#(
   parameter int IN_W = N_IN
)(
   // Clock and reset
   input wire logic CLOCK_I,
   input wire logic RST_B_I,
   // Avalon-MM register slave
   input wire logic [7:0] AVS_ADDRESS_I,
   input wire logic AVS_READ_I,
   input wire logic AVS_WRITE_I,
   input wire logic [31:0] AVS_WRITEDATA_I,
   output logic [31:0] AVS_READDATA_O,
   output logic AVS_WAITREQUEST_O,
   // Routing matrix side
   input wire logic [IN_W-1:0] MATRIX_I,
   input wire logic [N_CLK-1:0] GCLK_I,
   output logic [N_MC-1:0] MC_FEEDBACK_O,
   output logic [N_MC-1:0] PIN_FEEDBACK_O,
   // I/O cells
   input wire logic [N_MC-1:0] IO_PIN_I,
   output logic [N_MC-1:0] IO_PIN_O,
   output logic [N_MC-1:0] IO_PIN_OE_O
);
   // Mask words must fit one bus word
   if (IN_W < 1 || IN_W > 31) begin : g_bad_width
      $error("IN_W must lie in 1..31");
   end
   if (N_LOGIC != N_MC * CL_SZ || MAX_PT != 3 * CL_SZ) begin : g_bad_geom
      $error("Cluster geometry does not match macrocell count");
   end

   // True when a lies in the window base .. base+n-1
   function automatic logic in_win(input logic [7:0] a, input logic [7:0] base,
                                   input logic [7:0] n);
      in_win = (a >= base) && ((a - base) < n);
   endfunction

   // One product term; a term with no literal kept is held false
   function automatic logic term_eval(input logic [IN_W-1:0] x,
                                      input logic [IN_W-1:0] tm,
                                      input logic [IN_W-1:0] cm);
      term_eval = (|{tm, cm}) && (&((x | ~tm) & (~x | ~cm)));
   endfunction

   // Does cluster c, with steering code s, land on macrocell m
   function automatic logic steer_to(input logic [1:0] s, input int c, input int m);
      unique case (s)
         ST_NONE: steer_to = 1'b0;
         ST_DOWN: steer_to = (c > 0) && (c - 1 == m);
         ST_OWN: steer_to = (c == m);
         ST_UP: steer_to = (c < N_MC - 1) && (c + 1 == m);
      endcase
   endfunction

   // Configuration store
   logic run; // Logic running; configuration frozen
   logic [31:0] steer; // Two bits per cluster
   logic [CFG_W-1:0] mc_cfg [N_MC]; // Per-macrocell settings
   logic [IN_W-1:0] tmask [N_ALL]; // True-literal keep bits
   logic [IN_W-1:0] cmask [N_ALL]; // Complement-literal keep bits
   logic next_run;
   logic [31:0] next_steer;
   logic [CFG_W-1:0] next_mc_cfg [N_MC];
   logic [IN_W-1:0] next_tmask [N_ALL];
   logic [IN_W-1:0] next_cmask [N_ALL];
   // Bus handshake
   logic ack; // Answer cycle of the current request
   logic next_ack;
   logic [31:0] next_rdata;
   logic req;
   logic wr_take;
   logic [7:0] toff; // Offset into the term window
   logic [7:0] moff; // Offset into the macrocell window
   logic term_hit;
   logic mc_hit;
   // Array and allocator
   logic [N_ALL-1:0] term;
   logic [N_MC-1:0] cluster;
   logic [N_MC-1:0] sum;
   logic [3:0] oe_term;
   // Pin side
   logic [N_CLK-1:0] clk_prev; // Clock pin levels one cycle back
   logic [N_CLK-1:0] clk_edge;
   logic [N_MC-1:0] next_oe;

   assign req = AVS_READ_I || AVS_WRITE_I;
   assign AVS_WAITREQUEST_O = req && !ack; // One wait state per access
   assign wr_take = AVS_WRITE_I && ack;
   assign toff = AVS_ADDRESS_I - OFS_TERM;
   assign moff = AVS_ADDRESS_I - OFS_MC;
   assign term_hit = in_win(AVS_ADDRESS_I, OFS_TERM, 8'(2 * N_ALL));
   assign mc_hit = in_win(AVS_ADDRESS_I, OFS_MC, 8'(N_MC));

   // Register file next state; writes land at the answer edge
   always_comb begin
      next_run = run;
      next_steer = steer;
      next_mc_cfg = mc_cfg;
      next_tmask = tmask;
      next_cmask = cmask;
      next_ack = req && !ack;
      next_rdata = AVS_READDATA_O;
      // Read data fetched in the wait cycle, stands until next read
      if (AVS_READ_I && !ack) begin
         next_rdata = 32'h0000_0000; // Unmapped reads give zero
         if (AVS_ADDRESS_I == OFS_CTRL) begin
            next_rdata = 32'(run);
         end else if (AVS_ADDRESS_I == OFS_STATUS) begin
            next_rdata = {PIN_FEEDBACK_O, MC_FEEDBACK_O};
         end else if (AVS_ADDRESS_I == OFS_STEER) begin
            next_rdata = steer;
         end else if (mc_hit) begin
            next_rdata = 32'(mc_cfg[moff[3:0]]);
         end else if (term_hit) begin
            next_rdata = toff[0] ? 32'(cmask[toff[7:1]]) : 32'(tmask[toff[7:1]]);
         end
      end
      if (wr_take) begin
         if (AVS_ADDRESS_I == OFS_CTRL) begin
            next_run = AVS_WRITEDATA_I[CTRL_RUN];
         end else if (!run) begin
            // Fabric settings only change while the logic is stopped
            if (AVS_ADDRESS_I == OFS_STEER) begin
               next_steer = AVS_WRITEDATA_I;
            end else if (mc_hit) begin
               next_mc_cfg[moff[3:0]] = AVS_WRITEDATA_I[CFG_W-1:0];
            end else if (term_hit && toff[0]) begin
               next_cmask[toff[7:1]] = AVS_WRITEDATA_I[IN_W-1:0];
            end else if (term_hit) begin
               next_tmask[toff[7:1]] = AVS_WRITEDATA_I[IN_W-1:0];
            end
         end
      end
   end

   // Register file and bus answer flops
   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         run <= RST_RUN;
         steer <= RST_STEER;
         ack <= 1'b0;
         AVS_READDATA_O <= 32'h0000_0000;
         for (int i = 0; i < N_MC; i++) begin
            mc_cfg[i] <= RST_CFG;
         end
         for (int t = 0; t < N_ALL; t++) begin
            tmask[t] <= '0;
            cmask[t] <= '0;
         end
      end else begin
         run <= next_run;
         steer <= next_steer;
         ack <= next_ack;
         AVS_READDATA_O <= next_rdata;
         mc_cfg <= next_mc_cfg;
         tmask <= next_tmask;
         cmask <= next_cmask;
      end
   end

   // Product terms; only the matrix inputs reach the array
   always_comb begin
      for (int t = 0; t < N_ALL; t++) begin
         term[t] = term_eval(MATRIX_I, tmask[t], cmask[t]);
      end
      oe_term = term[T_OE +: 4];
   end

   // Allocator: each cluster of four goes to at most one cell, its own or a neighbour
   always_comb begin
      for (int c = 0; c < N_MC; c++) begin
         cluster[c] = |term[c * CL_SZ +: CL_SZ];
      end
      for (int m = 0; m < N_MC; m++) begin
         sum[m] = 1'b0;
         // Only clusters m-1..m+1 are looked at, so at most twelve terms
         for (int c = (m > 0 ? m - 1 : 0); c <= (m < N_MC - 1 ? m + 1 : m); c++) begin
            sum[m] = sum[m] | (cluster[c] & steer_to(steer[2*c +: 2], c, m));
         end
      end
   end

   // Clock pins compared with their level one cycle back; only a rise counts as an edge
   always_comb begin
      clk_edge = GCLK_I & ~clk_prev;
   end

   // Driver enables; a gated cell looks only at its bank's pair
   always_comb begin
      for (int i = 0; i < N_MC; i++) begin
         next_oe[i] = 1'b0;
         if (run) begin
            unique case (mc_cfg[i][MC_OE +: 2])
               OE_ON: next_oe[i] = 1'b1;
               OE_PT: next_oe[i] = oe_term[2 * (i / BANK) + 32'(mc_cfg[i][MC_OES])];
               default: next_oe[i] = 1'b0; // Off, and the spare code
            endcase
         end
      end
   end

   // Pin side flops; pin feedback runs whatever the driver does
   always_ff @(posedge CLOCK_I) begin
      if (!RST_B_I) begin
         clk_prev <= '0;
         IO_PIN_OE_O <= '0;
         PIN_FEEDBACK_O <= '0;
      end else begin
         clk_prev <= GCLK_I;
         IO_PIN_OE_O <= next_oe;
         PIN_FEEDBACK_O <= IO_PIN_I;
      end
   end

   // Sixteen macrocells, block-wide reset and preset terms
   for (genvar m = 0; m < N_MC; m++) begin : g_mc
      pld_macrocell u_mc (
         .clk_i(CLOCK_I),
         .rst_b_i(RST_B_I),
         .run_i(run),
         .cfg_i(mc_cfg[m]),
         .sum_i(sum[m]),
         .clk_edge_i(clk_edge),
         .ar_i(term[T_AR]),
         .ap_i(term[T_AP]),
         .out_o(MC_FEEDBACK_O[m])
      );
   end

   // Pin data equals the internal feedback; buried cells just keep OE off
   assign IO_PIN_O = MC_FEEDBACK_O;

   default clocking @(posedge CLOCK_I); endclocking
   default disable iff (!RST_B_I);

   wait_state_a: assert property (req && AVS_WAITREQUEST_O |=> !AVS_WAITREQUEST_O)
      else $error("Bus answer later than one wait state");
   status_read_a: assert property (AVS_READ_I && !ack && AVS_ADDRESS_I == OFS_STATUS
      |=> AVS_READDATA_O == {$past(PIN_FEEDBACK_O), $past(MC_FEEDBACK_O)})
      else $error("Status read mismatch");
   config_lock_a: assert property (wr_take && run && AVS_ADDRESS_I == OFS_STEER
      |=> $stable(steer)) else $error("Steering changed while running");
   steer_write_a: assert property (wr_take && !run && AVS_ADDRESS_I == OFS_STEER
      |=> steer == $past(AVS_WRITEDATA_I)) else $error("Steering write lost");
   pin_return_a: assert property (##1 PIN_FEEDBACK_O == $past(IO_PIN_I))
      else $error("Pin feedback wrong");
   sum_bound_a: assert property (sum[0] == ((cluster[0] && steer[1:0] == ST_OWN) ||
      (cluster[1] && steer[3:2] == ST_DOWN))) else $error("Cell 0 fed from far cluster");
   for (genvar i = 0; i < N_MC; i++) begin : g_chk
      driver_off_a: assert property (mc_cfg[i][MC_OE +: 2] == OE_OFF
         |=> !IO_PIN_OE_O[i]) else $error("Disabled driver enabled");
      bank_pair_a: assert property (run && mc_cfg[i][MC_OE +: 2] == OE_PT &&
         oe_term[2 * (i / BANK) +: 2] == 2'h0 |=> !IO_PIN_OE_O[i])
         else $error("Driver gated by other bank");
   end

   write_c: cover property (wr_take && !run);
   gated_c: cover property (run && |(IO_PIN_OE_O & ~{N_MC{1'b0}}) && oe_term != 4'h0);
   run_c: cover property (run && term[T_AR]);
endmodule

/* pld_pins.sv */
// Board model: resolves each I/O pin from the block's driver and the board.
// Assumes the bench supplies board levels and a per-pin drive flag.
`timescale 1ns/1ps
module pld_pins
   import pld_pkg::*;
(
   // Clock
   input wire logic clk_i,
   // From the block
   input wire logic [N_MC-1:0] pin_i,
   input wire logic [N_MC-1:0] oe_i,
   // From the board
   input wire logic [N_MC-1:0] ext_i,
   input wire logic [N_MC-1:0] ext_en_i,
   // Level seen at the pins
   output logic [N_MC-1:0] level_o
);
   logic [N_MC-1:0] drift = '0; // Undriven pins have no pull, so they wander

   // Floating level flips each cycle, never a stale copy
   always_ff @(posedge clk_i) begin
      drift <= ~level_o;
   end

   // Block driver first, else the board, else the floating level
   always_comb begin
      for (int k = 0; k < N_MC; k++) begin
         level_o[k] = oe_i[k] ? pin_i[k] : (ext_en_i[k] ? ext_i[k] : drift[k]);
      end
   end
endmodule

/* pld_block_tb.sv */
// Self-checking bench for the logic block: registers, terms, cells, pins.
// Assumes a 200 MHz core clock and the board model beside the block.
`timescale 1ns/1ps
module pld_block_tb;
   import pld_pkg::*;
   // Bus and core signals
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] adr = 8'h00;
   logic rd_en = 1'b0;
   logic wr_en = 1'b0;
   logic [31:0] wdata = 32'h0000_0000;
   logic [31:0] rdata;
   logic waitreq;
   // Matrix, clock pins and I/O
   logic [N_IN-1:0] matrix = '0;
   logic [N_CLK-1:0] gclk = '0;
   logic [N_MC-1:0] mc_fb, pin_fb, pin_in, pin_out, pin_oe;
   logic [N_MC-1:0] ext = '0;
   logic snap = 1'b0; // Marks a cycle whose pin outputs are judged
   // Expectation queues and state
   logic [47:0] rd_q[$];
   logic [47:0] pin_q[$];
   int bad_count = 0;
   int total_checks = 0;
   logic [31:0] seed = 32'hCE05CF83;
   logic q3 = 1'b0; // Expected state of the D cell
   logic q15 = 1'b0; // Expected state of the T cell
   logic [N_MC-1:0] last_oe, last_out, last_e;
   // Configuration words, address then data
   logic [39:0] cfg_tab [14] = '{40'h40_0000_0001, 40'h48_0000_0002, 40'h4B_0000_0100,
      40'h44_0000_0200, 40'h45_0000_0200, 40'h50_0000_0004, 40'hB8_0000_0008,
      40'hC6_0000_0010, 40'hC8_0000_0020, 40'hCA_0000_0040, 40'h02_8000_0036,
      40'h10_0000_0020, 40'h13_0000_0011, 40'h1F_0000_00CF};

   pld_block #(.IN_W(N_IN)) DUT (.CLOCK_I(clk), .RST_B_I(rst_b), .AVS_ADDRESS_I(adr),
      .AVS_READ_I(rd_en), .AVS_WRITE_I(wr_en), .AVS_WRITEDATA_I(wdata),
      .AVS_READDATA_O(rdata), .AVS_WAITREQUEST_O(waitreq), .MATRIX_I(matrix),
      .GCLK_I(gclk), .MC_FEEDBACK_O(mc_fb), .PIN_FEEDBACK_O(pin_fb), .IO_PIN_I(pin_in),
      .IO_PIN_O(pin_out), .IO_PIN_OE_O(pin_oe));
   pld_pins pins (.clk_i(clk), .pin_i(pin_out), .oe_i(pin_oe), .ext_i(ext),
      .ext_en_i(16'hFFFF), .level_o(pin_in));

   // 200 MHz core clock
   initial begin
      forever #2.5 clk = ~clk;
   end

   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction

   task automatic check(input logic [47:0] seen, input logic [47:0] exp);
      total_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask

   // One bus access; request held until waitrequest is seen low at an edge
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic w;
      int n = 0;
      @(posedge clk);
      adr <= a;
      wdata <= d;
      wr_en <= wr;
      rd_en <= !wr;
      do begin
         @(posedge clk);
         w = waitreq; // Value as it stood at this rising edge
         n++;
      end while (w !== 1'b0 && n < 20);
      if (w !== 1'b0) begin
         bad_count++;
         complete_run();
      end
      wr_en <= 1'b0;
      rd_en <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp);
      rd_q.push_back({16'h0000, exp});
      bus(1'b0, a, 32'h0000_0000);
   endtask

   // Drive matrix and clock pins, predict the cells, judge one cycle later
   task automatic step(input logic [N_IN-1:0] m, input logic [N_CLK-1:0] g,
         input logic [N_MC-1:0] e);
      logic [N_MC-1:0] out = '0;
      logic [N_MC-1:0] oe = '0;
      @(posedge clk);
      if (m[5]) begin
         q3 = 1'b0;
         q15 = 1'b0;
      end else if (m[6]) begin
         q3 = 1'b1;
         q15 = 1'b1;
      end else begin
         if (g[2] && !gclk[2]) q3 = m[2]; // D loads on its own clock's rise
         if (g[1] && !gclk[1] && m[3]) q15 = !q15; // T flips only on true sum
      end
      out[0] = m[0] | m[1] | !m[8]; // Two clusters, contradictory term stays false
      oe[0] = 1'b1;
      out[3] = q3;
      out[15] = !q15;
      oe[15] = m[4];
      matrix <= m;
      gclk <= g;
      ext <= e;
      last_oe = oe;
      last_out = out;
      last_e = e;
      @(posedge clk);
      snap <= 1'b1;
      pin_q.push_back({oe, out, out});
      @(posedge clk);
      snap <= 1'b0;
   endtask

   // Watcher: takes the oldest note whenever a result shows
   always @(posedge clk) begin
      // Register read answer, taken at the edge where waitrequest is low
      if (rd_en === 1'b1 && waitreq === 1'b0 && rd_q.size() > 0) begin
         check({16'h0000, rdata}, rd_q.pop_front());
      end
      // Cell outputs and drivers of a judged cycle
      if (snap === 1'b1 && pin_q.size() > 0) begin
         check({pin_oe, pin_out, mc_fb}, pin_q.pop_front());
      end
   end

   // Hang guard
   initial begin
      repeat (20000) @(posedge clk);
      bad_count++;
      complete_run();
   end

   // Main sequence
   initial begin
      logic [31:0] r;
      repeat (12) @(posedge clk);
      rst_b <= 1'b1;
      foreach (cfg_tab[i]) rd(cfg_tab[i][39:32], 32'h0000_0000); // Cleared by reset
      rd(8'h30, 32'h0000_0000); // Unmapped reads zero
      foreach (cfg_tab[i]) bus(1'b1, cfg_tab[i][39:32], cfg_tab[i][31:0]);
      foreach (cfg_tab[i]) rd(cfg_tab[i][39:32], cfg_tab[i][31:0]);
      bus(1'b1, OFS_CTRL, 32'h0000_0001);
      for (int i = 0; i < 64; i++) begin
         seed = lfsr(seed);
         r = seed;
         // Reset and preset terms only every eighth step, so the flops get to move
         step({r[25:7], (i % 8 == 7) ? r[6:5] : 2'b00, r[4:0]},
            r[11:8], r[31:16]);
      end
      rd(OFS_STATUS, {(last_oe & last_out) | (~last_oe & last_e), last_out});
      bus(1'b1, OFS_STEER, 32'hFFFF_FFFF);
      rd(OFS_STEER, 32'h8000_0036); // Ignored while running
      bus(1'b1, OFS_CTRL, 32'h0000_0000);
      // Drivers drop one edge after the stop, pin feedback one edge later
      repeat (2) @(posedge clk);
      rd(OFS_STATUS, {last_e, 16'h0000}); // Stopped block drives nothing
      complete_run();
   end
endmodule
